// [bsbi_pkg.sv]
/*
 Constants and types for the bit-skip, branch, bit-set and pointer-load
 execution block. Assumes one instruction clock and a core that decodes
 opcodes into the operation code and operand fields held here.
*/
package bsbi_pkg;
   typedef enum logic [1:0] {
      OP_SKIP_IF_BIT_HIGH    = 2'b00,
      OP_JUMP_BY_ACC_OFFSET  = 2'b01,
      OP_SET_REGISTER_BIT    = 2'b10,
      OP_LOAD_ACC_VIA_POINTER = 2'b11
   } bsbi_op_t;

   typedef enum logic {
      ST_EXEC = 1'b0,
      ST_NOP  = 1'b1
   } bsbi_state_t;

   localparam int          ADDR_W        = 7;
   localparam int          PTR_W         = 16;
   localparam int          OFS_W         = 6;
   localparam int          CODE_W        = 2;
   localparam int          DATA_W        = 8;
   localparam int          BIT_W         = 3;
   // Update code: bit 0 picks decrement, bit 1 picks post-update
   localparam int          CODE_DEC_BIT  = 0;
   localparam int          CODE_POST_BIT = 1;
   localparam logic [1:0]  CODE_PRE_INC  = 2'h0;
   localparam logic [1:0]  CODE_PRE_DEC  = 2'h1;
   localparam logic [1:0]  CODE_POST_INC = 2'h2;
   localparam logic [1:0]  CODE_POST_DEC = 2'h3;
   localparam logic [6:0]  WINDOW0_ADDR  = 7'h00;
   localparam logic [6:0]  WINDOW1_ADDR  = 7'h01;
   localparam logic [15:0] PTR_RESET     = 16'h0000;
   localparam logic [15:0] PTR_STEP      = 16'h0001;
   localparam logic [7:0]  DATA_RESET    = 8'h00;
   localparam logic [7:0]  BIT_ONE       = 8'h01;
endpackage : bsbi_pkg

// [bsbi_exec.sv]
/*
 Execution of skip_if_bit_high, jump_by_acc_offset, set_register_bit and
 load_acc_via_pointer, with the file registers, accumulator, zero flag,
 program counter and both file_pointer registers held in flip-flops.
 Assumes the core presents one decoded instruction per cycle on
 instr_valid and throws away its fetched successor while discard_next
 is high.
*/
// Operation
// - Skip tests bit b of file f
// - Bit high: discard successor, run NOP
// - Jump loads PC plus unsigned accumulator
// - Jump takes two cycles, successor flushed
// - Set-bit forces one bit, flags untouched
// - Pointer load copies indirect data to accumulator
// - Update code selects pre/post increment/decrement
// - Window locations keep storage, reached by side port or pointer only
// - Window accesses go to pointer's location
// - Sixteen-bit pointers wrap both ways
`timescale 1ns/1ns
module bsbi_exec #(
   parameter int PC_W = 15
) (
   input  wire logic                           mclk,
   input  wire logic                           reset_n,
   input  wire logic                           instr_valid,
   input  wire bsbi_pkg::bsbi_op_t             instr_op,
   input  wire logic [bsbi_pkg::ADDR_W-1:0]    instr_f,
   input  wire logic [bsbi_pkg::BIT_W-1:0]     instr_b,
   input  wire logic                           instr_n,
   input  wire logic [bsbi_pkg::CODE_W-1:0]    pointer_update_code,
   input  wire logic                           instr_rel,
   input  wire logic [bsbi_pkg::OFS_W-1:0]     instr_k,
   input  wire logic                           acc_wr,
   input  wire logic [bsbi_pkg::DATA_W-1:0]    acc_wdata,
   input  wire logic                           file_wr,
   input  wire logic [bsbi_pkg::ADDR_W-1:0]    file_waddr,
   input  wire logic [bsbi_pkg::DATA_W-1:0]    file_wdata,
   output logic      [PC_W-1:0]                pc,
   output logic      [bsbi_pkg::DATA_W-1:0]    acc,
   output logic                                zero,
   output logic                                discard_next,
   output logic      [bsbi_pkg::PTR_W-1:0]     file_pointer0,
   output logic      [bsbi_pkg::PTR_W-1:0]     file_pointer1
);
   import bsbi_pkg::*;

   localparam int DEPTH = 2 ** ADDR_W;

   bsbi_state_t      state;
   bsbi_state_t      next_state;
   logic [DATA_W-1:0] file_mem [DEPTH];

   function automatic logic [ADDR_W-1:0] resolve(
      input logic [ADDR_W-1:0] f,
      input logic [PTR_W-1:0]  p0,
      input logic [PTR_W-1:0]  p1
   );
      logic [ADDR_W-1:0] r;
      r = f;
      if (f == WINDOW0_ADDR) begin
         r = p0[ADDR_W-1:0];
      end
      else if (f == WINDOW1_ADDR) begin
         r = p1[ADDR_W-1:0];
      end
      return r;
   endfunction : resolve

   wire              take      = instr_valid && (state == ST_EXEC);
   wire              is_skip   = take && (instr_op == OP_SKIP_IF_BIT_HIGH);
   wire              is_jump   = take && (instr_op == OP_JUMP_BY_ACC_OFFSET);
   wire              is_set    = take && (instr_op == OP_SET_REGISTER_BIT);
   wire              is_load   = take &&
                                 (instr_op == OP_LOAD_ACC_VIA_POINTER);

   // Bit operations follow the window too
   wire [ADDR_W-1:0] bit_addr  = resolve(instr_f, file_pointer0,
                                         file_pointer1);
   wire [DATA_W-1:0] bit_word  = file_mem[bit_addr];
   // Tested bit of the addressed register
   wire              bit_high  = bit_word[instr_b];
   wire              skip_hit  = is_skip && bit_high;

   wire [PTR_W-1:0]  sel_ptr   = instr_n ? file_pointer1 : file_pointer0;
   wire [PTR_W-1:0]  ptr_inc   = sel_ptr + PTR_STEP;
   wire [PTR_W-1:0]  ptr_dec   = sel_ptr - PTR_STEP;
   wire [PTR_W-1:0]  k_ext     = {{(PTR_W-OFS_W){instr_k[OFS_W-1]}},
                                  instr_k};
   wire [PTR_W-1:0]  ptr_ofs   = sel_ptr + k_ext;
   wire              code_dec  = pointer_update_code[CODE_DEC_BIT];
   wire              code_post = pointer_update_code[CODE_POST_BIT];
   wire [PTR_W-1:0]  ptr_step  = code_dec ? ptr_dec : ptr_inc;
   // Pre uses updated, post uses old
   wire [PTR_W-1:0]  eff_addr  = instr_rel ? ptr_ofs :
                                 (code_post ? sel_ptr : ptr_step);
   wire [PTR_W-1:0]  next_sel  = instr_rel ? sel_ptr : ptr_step;
   wire [DATA_W-1:0] load_data = file_mem[eff_addr[ADDR_W-1:0]];

   wire [PC_W-1:0]   acc_ext   = {{(PC_W-DATA_W){1'b0}}, acc};
   wire [PC_W-1:0]   next_pc   = is_jump ? pc + acc_ext :
                                 skip_hit ? pc + PC_W'(1) :
                                 take ? pc + PC_W'(1) : pc;

   // Taken skip or jump inserts one NOP
   assign next_state = (skip_hit || is_jump) ? ST_NOP : ST_EXEC;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state        <= ST_EXEC;
         discard_next <= 1'b0;
      end
      else begin
         state        <= next_state;
         discard_next <= (next_state == ST_NOP);
      end
   end

   // PC redirected while successor is flushed
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pc <= '0;
      end
      else begin
         pc <= next_pc;
      end
   end

   // Zero flag from loaded value only
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         acc  <= DATA_RESET;
         zero <= 1'b0;
      end
      else if (is_load) begin
         acc  <= load_data;
         zero <= (load_data == DATA_RESET);
      end
      else if (acc_wr) begin
         acc  <= acc_wdata;
      end
   end

   // Only the pointer picked by instr_n updated by selected step; offset form keeps it
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         file_pointer0 <= PTR_RESET;
         file_pointer1 <= PTR_RESET;
      end
      else if (is_load && !instr_n) begin
         file_pointer0 <= next_sel;
      end
      else if (is_load && instr_n) begin
         file_pointer1 <= next_sel;
      end
   end

   // Instruction write wins over the side port on a clash
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_file
         always_ff @(posedge mclk) begin
            if (!reset_n) begin
               file_mem[gi] <= DATA_RESET;
            end
            // Only bit b is forced high
            else if (is_set && (bit_addr == ADDR_W'(gi))) begin
               file_mem[gi] <= file_mem[gi] | (BIT_ONE << instr_b);
            end
            else if (file_wr && (file_waddr == ADDR_W'(gi))) begin
               file_mem[gi] <= file_wdata;
            end
         end
      end
   endgenerate

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence s_skip_taken;
      is_skip && bit_high;
   endsequence
   sequence s_one_nop;
      discard_next && !take ##1 !discard_next;
   endsequence

   property p_skip_clear;
      is_skip && !bit_high |=> !discard_next && pc == $past(pc) + PC_W'(1);
   endproperty
   a_skip_clear: assert property (p_skip_clear)
      else $error("skip on clear bit altered flow");

   property p_skip_set;
      s_skip_taken |=> s_one_nop;
   endproperty
   a_skip_set: assert property (p_skip_set)
      else $error("taken skip did not insert exactly one NOP");

   property p_jump_target;
      is_jump |=> pc == $past(pc) + {{(PC_W-DATA_W){1'b0}}, $past(acc)};
   endproperty
   a_jump_target: assert property (p_jump_target)
      else $error("jump target wrong");

   property p_jump_two;
      is_jump |=> s_one_nop and ($stable(zero) [*2]);
   endproperty
   a_jump_two: assert property (p_jump_two)
      else $error("jump not two cycles or flag changed");

   property p_set_bit;
      is_set |=> file_mem[$past(bit_addr)] ==
                 ($past(bit_word) | (BIT_ONE << $past(instr_b)))
                 && $stable(zero);
   endproperty
   a_set_bit: assert property (p_set_bit)
      else $error("set-bit result wrong");

   property p_load_acc;
      is_load |=> acc == $past(load_data);
   endproperty
   a_load_acc: assert property (p_load_acc)
      else $error("pointer load data wrong");

   property p_post_inc;
      is_load && !instr_rel && !instr_n &&
      pointer_update_code == CODE_POST_INC
      |=> file_pointer0 == $past(file_pointer0) + PTR_STEP
          && acc == $past(file_mem[file_pointer0[ADDR_W-1:0]]);
   endproperty
   a_post_inc: assert property (p_post_inc)
      else $error("post-increment on pointer 0 wrong");

   property p_pre_dec_wrap;
      is_load && !instr_rel && instr_n && file_pointer1 == PTR_RESET &&
      pointer_update_code == CODE_PRE_DEC
      |=> file_pointer1 == {PTR_W{1'b1}};
   endproperty
   a_pre_dec_wrap: assert property (p_pre_dec_wrap)
      else $error("pointer did not wrap below zero");

   property p_rel_keep;
      is_load && instr_rel |=> $stable(file_pointer0) &&
                               $stable(file_pointer1);
   endproperty
   a_rel_keep: assert property (p_rel_keep)
      else $error("offset form moved a pointer");

   property p_zero_flag;
      is_load |=> zero == ($past(load_data) == DATA_RESET);
   endproperty
   a_zero_flag: assert property (p_zero_flag)
      else $error("zero flag wrong after load");

   property p_window_skip;
      is_skip && instr_f == WINDOW0_ADDR |->
      bit_high == file_mem[file_pointer0[ADDR_W-1:0]][instr_b];
   endproperty
   a_window_skip: assert property (p_window_skip)
      else $error("window access not redirected");

   property p_window_set;
      is_set && instr_f == WINDOW1_ADDR && file_pointer1[ADDR_W-1:0] !=
      WINDOW1_ADDR |=> $stable(file_mem[WINDOW1_ADDR]) || $past(file_wr);
   endproperty
   a_window_set: assert property (p_window_set)
      else $error("window location itself was written");
endmodule : bsbi_exec

// [tb_bsbi_exec.sv]
/*
 Self-checking bench for bsbi_exec: pointer-wrap corners, then a random
 instruction stream, each cycle checked against a bench model.
 Assumes one result cycle and a NOP slot after a taken skip or a jump.
*/
`timescale 1ns/1ns
module tb_bsbi_exec;
   import bsbi_pkg::*;
   logic                  mclk, reset_n, instr_valid, instr_n, instr_rel;
   logic                  acc_wr, file_wr, zero, discard_next;
   bsbi_op_t              instr_op;
   logic [6:0]            instr_f, file_waddr;
   logic [2:0]            instr_b;
   logic [1:0]            pointer_update_code;
   logic [5:0]            instr_k;
   logic [7:0]            acc_wdata, file_wdata, acc, m_acc;
   logic [14:0]           pc, m_pc;
   logic [15:0]           file_pointer0, file_pointer1, lfsr, r, s;
   logic [15:0]           m_ptr [2];
   logic [7:0]            m_file [128];
   logic                  m_zero, m_dn;
   int                    n_errors, total_checks, cycles;

   bsbi_exec dut (.mclk(mclk), .reset_n(reset_n), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_f(instr_f), .instr_b(instr_b),
      .instr_n(instr_n), .pointer_update_code(pointer_update_code),
      .instr_rel(instr_rel), .instr_k(instr_k), .acc_wr(acc_wr),
      .acc_wdata(acc_wdata), .file_wr(file_wr), .file_waddr(file_waddr),
      .file_wdata(file_wdata), .pc(pc), .acc(acc), .zero(zero),
      .discard_next(discard_next), .file_pointer0(file_pointer0),
      .file_pointer1(file_pointer1));

   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction : rnd

   // Window addresses follow the pointer's low bits
   function automatic logic [6:0] win(input logic [6:0] f);
      return (f == WINDOW0_ADDR) ? m_ptr[0][6:0] :
             (f == WINDOW1_ADDR) ? m_ptr[1][6:0] : f;
   endfunction : win

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   // Model one edge from the inputs just driven, then compare
   task automatic apply();
      logic [7:0]  rd, fw, a0;
      logic [15:0] p, np, ea;
      logic [6:0]  tgt;
      p = m_ptr[instr_n];
      np = pointer_update_code[CODE_DEC_BIT] ? p - 16'h0001 : p + 16'h0001;
      ea = instr_rel ? p + {{10{instr_k[5]}}, instr_k} :
           (pointer_update_code[CODE_POST_BIT] ? p : np);
      tgt = win(instr_f);
      rd = m_file[tgt];
      fw = m_file[ea[6:0]];
      a0 = m_acc;
      if (acc_wr) m_acc = acc_wdata;
      if (file_wr) m_file[file_waddr] = file_wdata;
      if (instr_valid && !m_dn) begin
         m_dn = 1'b0;
         m_pc = m_pc + 15'h0001;
         case (instr_op)
            OP_SKIP_IF_BIT_HIGH: m_dn = rd[instr_b];
            OP_JUMP_BY_ACC_OFFSET: begin
               m_pc = m_pc - 15'h0001 + {7'h00, a0};
               m_dn = 1'b1;
            end
            // Set-bit wins over a side-port write of the same entry
            OP_SET_REGISTER_BIT: m_file[tgt] = rd | (8'h01 << instr_b);
            default: begin
               m_acc = fw;
               m_zero = (fw == 8'h00);
               if (!instr_rel) m_ptr[instr_n] = np;
            end
         endcase
      end else begin
         m_dn = 1'b0;
      end
      @(negedge mclk);
      chk({1'b0, pc}, {1'b0, m_pc});
      chk({8'h00, acc}, {8'h00, m_acc});
      chk({15'h0000, zero}, {15'h0000, m_zero});
      chk({15'h0000, discard_next}, {15'h0000, m_dn});
      chk(file_pointer0, m_ptr[0]);
      chk(file_pointer1, m_ptr[1]);
   endtask : apply

   task automatic ins(input logic [1:0] op, input logic [6:0] f,
                      input logic [2:0] b, input logic [3:0] nc,
                      input logic [5:0] k);
      instr_valid = 1'b1;
      instr_op = bsbi_op_t'(op);
      instr_f = f;
      instr_b = b;
      {instr_rel, instr_n, pointer_update_code} = nc;
      instr_k = k;
      apply();
   endtask : ins

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         n_errors++;
         finish_test();
      end
   end

   initial begin
      lfsr = 16'h0034;
      {instr_valid, instr_n, instr_rel, acc_wr, file_wr} = 5'h00;
      instr_op = OP_SKIP_IF_BIT_HIGH;
      {instr_f, file_waddr, instr_b, pointer_update_code} = 19'h00000;
      {instr_k, acc_wdata, file_wdata} = 22'h000000;
      {m_pc, m_acc, m_zero, m_dn} = 25'h0000000;
      m_ptr[0] = PTR_RESET;
      m_ptr[1] = PTR_RESET;
      reset_n = 1'b0;
      repeat (20) @(negedge mclk);
      reset_n = 1'b1;
      file_wr = 1'b1;
      for (int i = 0; i < 128; i++) begin
         file_waddr = 7'(i);
         file_wdata = (i == 5) ? 8'h00 : 8'(rnd());
         m_file[i] = DATA_RESET;
         apply();
      end
      file_wr = 1'b0;
      // Pointer 1 wraps down then up, pointer 0 likewise
      ins(2'h3, 7'h00, 3'h0, 4'h5, 6'h00);
      ins(2'h3, 7'h00, 3'h0, 4'h4, 6'h00);
      ins(2'h3, 7'h00, 3'h0, 4'h1, 6'h00);
      ins(2'h3, 7'h00, 3'h0, 4'h2, 6'h00);
      ins(2'h3, 7'h00, 3'h0, 4'h7, 6'h00);
      ins(2'h3, 7'h00, 3'h0, 4'h8, 6'h20);
      // Pointer 1 is FFFFh here, so offset 6 reaches the zero entry
      ins(2'h3, 7'h00, 3'h0, 4'hC, 6'h06);
      ins(2'h2, 7'h10, 3'h7, 4'h0, 6'h00);
      ins(2'h0, 7'h10, 3'h7, 4'h0, 6'h00);
      ins(2'h1, 7'h10, 3'h0, 4'h0, 6'h00);
      ins(2'h1, 7'h10, 3'h0, 4'h0, 6'h00);
      ins(2'h0, 7'h05, 3'h0, 4'h0, 6'h00);
      ins(2'h0, 7'h05, 3'h0, 4'h0, 6'h00);
      ins(2'h2, WINDOW1_ADDR, 3'h3, 4'h0, 6'h00);
      ins(2'h0, WINDOW1_ADDR, 3'h3, 4'h0, 6'h00);
      for (int i = 0; i < 2000; i++) begin
         r = rnd();
         s = rnd();
         acc_wr = r[15] & r[14];
         acc_wdata = s[7:0];
         file_wr = r[13] & r[12];
         file_waddr = s[14:8];
         file_wdata = r[7:0];
         instr_valid = r[11] | r[10];
         instr_op = bsbi_op_t'(r[1:0]);
         instr_f = r[9] ? {6'h00, r[2]} : s[6:0];
         instr_b = r[5:3];
         {instr_rel, instr_n, pointer_update_code} = {s[15], r[8:6]};
         instr_k = s[5:0];
         apply();
      end
      finish_test();
   end
endmodule : tb_bsbi_exec
